// ### hw/cgc_params.svh
// constants for the cycle-control glue block
// assumes inclusion by the cgc_glue module only
`ifndef CGC_PARAMS_SVH
`define CGC_PARAMS_SVH

// ----------------------------------------
// i/o address windows
// ----------------------------------------
`define CGC_IO_WAIT_TOP  8'h3f
`define CGC_REG_BASE     8'hf0
`define CGC_REG_TOP      8'hff
`define CGC_UPPER_CS_LO  3'd5

// ----------------------------------------
// opcode decode
// ----------------------------------------
`define CGC_PFX_BYTE     8'hed
`define CGC_RET_BYTE     8'h4d
`define CGC_RET_MAX_WS   4'h2

// ----------------------------------------
// wait and reset timing
// ----------------------------------------
`define CGC_ACK_EXTRA_WS 4'h2
`define CGC_RST_CLKS     5'h10
`define CGC_POR_CLKS     1024
`define CGC_HALT_TSTATE  3'h4

`endif

// ### hw/cgc_pkg.sv
// types shared by the cycle-control glue files
// assumes cgc_params.svh sits on the include path
package cgc_pkg;

  // ----------------------------------------
  // processor bus pins, all active low except address and data
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        memory_request_n;
    logic        io_request_n;
    logic        rd_n;
    logic        wr_n;
    logic        machine_cycle_one_n;
    logic        halt_n;
    logic        int_n;
    logic        nmi_n;
    logic        external_reset_in_n;
  } cgc_bus_t;

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  typedef struct packed {
    logic       en;
    logic       is_io;
    logic [5:0] val;
  } cgc_cs_cfg_t;

  typedef struct packed {
    logic                  master_en;
    logic                  dram_en;
    logic                  periph_if_en;
    logic                  pd_en;
    logic                  wdt_en;
    logic                  op_wait_en;
    logic [3:0]            ss_top;
    logic [1:0]            io_ws;
    logic [1:0]            mem_ws;
    logic [1:0]            ack_ws;
    logic [1:0]            ret_ws;
    cgc_cs_cfg_t [7:0]     cs;
  } cgc_cfg_t;

  typedef enum logic [1:0] {RS_POR, RS_IDLE, RS_ARMED, RS_HOLD} cgc_rst_state_t;

endpackage

// ### hw/cgc_sync.sv
// two-flop synchroniser for a vector of pins
// assumes bits are independent levels; no word coherence
`timescale 1ns/1ps
module cgc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta <= '1;
      q_o  <= '1;
    end
    else if (ce_i)
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ### hw/cgc_glue.sv
// cycle-control glue: selects, dram strobes, waits, strobes, clock, resets
// assumes processor pins arrive asynchronous; config ports are static
//
// Operation
// - upper selects 16 ports, lower 4
// - i/o waits only for ports 00-3f
// - peripheral read/write strobes in i/o cycles
// - write strobe only inside data-valid window
// - unmatched memory access is dynamic memory
// - memory selects latched, held until request ends
// - row strobe at second t-state rise
// - column strobe at second t-state fall
// - prefix byte adds wait to next fetch
// - non-4d releases; 4d adds up to 2
// - optional one wait on opcode fetch
// - static waits when memory select active
// - exactly one memory interface per access
// - acknowledge waits and delayed buffered request
// - acknowledge and read strobes during acknowledge
// - halt stops clock in t4 low
// - interrupt or reset restarts clock
// - power-down and peripheral strobes exclusive
// - power-on holds reset and strobes
// - external reset aligned to cycle one
// - reset in power-down restarts clock first
// - reset lasts 16 clocks, strobes active
// - watchdog expiry gives full reset
// - i/o selects latched until request ends
// - register write is f0-ff without read
`timescale 1ns/1ps
`include "cgc_params.svh"
module cgc_glue #(
  parameter int POR_CLKS = `CGC_POR_CLKS
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  input  wire cgc_pkg::cgc_bus_t bus_i,
  input  wire cgc_pkg::cgc_cfg_t cfg_i,
  input  wire logic             wdt_expire_i,
  output logic                  cpu_clk_o,
  output logic                  static_select_n_o,
  output logic [7:0]            decoded_selects_n_o,
  output logic                  ras_n_o,
  output logic                  cas_n_o,
  output logic                  wait_n_o,
  output logic                  periph_read_strobe_n_o,
  output logic                  periph_write_strobe_n_o,
  output logic                  irq_ack_strobe_n_o,
  output logic                  buffered_io_request_n_o,
  output logic                  system_reset_out_n_o,
  output logic                  reg_write_o,
  output logic                  cfg_conflict_o
);
  import cgc_pkg::*;

  // ----------------------------------------
  // pin capture and edges
  // ----------------------------------------
  cgc_bus_t b;
  logic memory_request_q, io_request_q, m1_q, xrst_q;

  cgc_sync #(.W($bits(cgc_bus_t))) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .d_i       (bus_i),
    .q_o       (b)
  );

  logic mem_act, io_act, m1_act, ack_act, fetch;
  logic mem_start, io_start, m1_fall, xrst_fall;
  assign mem_act   = !b.memory_request_n;
  assign io_act    = !b.io_request_n;
  assign m1_act    = !b.machine_cycle_one_n;
  assign ack_act   = io_act && m1_act;
  assign fetch     = mem_act && m1_act;
  assign mem_start = mem_act && memory_request_q;
  assign io_start  = io_act && io_request_q;
  assign m1_fall   = m1_act && m1_q;
  assign xrst_fall = !b.external_reset_in_n && xrst_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      memory_request_q <= 1'b1;
      io_request_q <= 1'b1;
      m1_q   <= 1'b1;
      xrst_q <= 1'b1;
    end
    else if (ce_i)
    begin
      memory_request_q <= b.memory_request_n;
      io_request_q <= b.io_request_n;
      m1_q   <= b.machine_cycle_one_n;
      xrst_q <= b.external_reset_in_n;
    end
  end

  // ----------------------------------------
  // mode exclusion
  // ----------------------------------------
  // both requested means neither runs, so no half-working setup
  logic pif_en, pd_en;
  assign cfg_conflict_o = cfg_i.pd_en && cfg_i.periph_if_en;
  assign pif_en = cfg_i.periph_if_en && !cfg_conflict_o;
  assign pd_en  = cfg_i.pd_en && !cfg_conflict_o;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic mem_hit_f(cgc_cs_cfg_t c, logic [3:0] lo, logic [3:0] a);
    mem_hit_f = c.en && !c.is_io && (a <= c.val[3:0]) && (a > lo);
  endfunction

  function automatic logic io_hit_f(cgc_cs_cfg_t c, logic upper, logic [7:0] a);
    if (upper)
      io_hit_f = c.en && c.is_io && (a[7:4] == c.val[5:2]);
    else
      io_hit_f = c.en && c.is_io && (a[7:2] == c.val);
  endfunction

  logic [7:0] mem_hit, io_hit;
  logic       ss_hit;
  always_comb
  begin
    logic [3:0] lo;
    lo = cfg_i.ss_top;
    for (int i = 0; i < 8; i++)
    begin
      mem_hit[i] = cfg_i.master_en && mem_hit_f(cfg_i.cs[i], lo, b.addr[15:12]);
      io_hit[i]  = cfg_i.master_en
                   && io_hit_f(cfg_i.cs[i], i >= `CGC_UPPER_CS_LO, b.addr[7:0]);
      lo = cfg_i.cs[i].val[3:0];
    end
    ss_hit = cfg_i.master_en && (b.addr[15:12] <= cfg_i.ss_top);
  end

  // ----------------------------------------
  // latched selects
  // ----------------------------------------
  logic       ss_sel, dram_acc;
  logic [7:0] cs_sel;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ss_sel   <= 1'b0;
      cs_sel   <= 8'h00;
      dram_acc <= 1'b0;
    end
    else if (ce_i)
    begin
      if (mem_start)
      begin
        ss_sel   <= ss_hit;
        cs_sel   <= mem_hit;
        dram_acc <= !ss_hit && !(|mem_hit) && cfg_i.dram_en;
      end
      else if (io_start && !m1_act)
        cs_sel <= io_hit;
      else if (!mem_act && !io_act)
      begin
        ss_sel   <= 1'b0;
        cs_sel   <= 8'h00;
        dram_acc <= 1'b0;
      end
    end
  end

  assign static_select_n_o   = !ss_sel;
  assign decoded_selects_n_o = ~cs_sel;

  // ----------------------------------------
  // processor clock and power-down
  // ----------------------------------------
  logic       ph, stopped, rise_e, fall_e;
  logic [2:0] t_cnt;
  assign rise_e    = !ph && !stopped;
  assign fall_e    = ph;
  assign cpu_clk_o = ph;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ph <= 1'b0;
    else if (ce_i)
      ph <= rise_e;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      t_cnt <= 3'h0;
    else if (ce_i)
    begin
      if (m1_fall)
        t_cnt <= 3'h1;
      else if (rise_e && t_cnt != 3'h7)
        t_cnt <= t_cnt + 3'h1;
    end
  end

  // wake has priority over entry so a pending interrupt never sleeps
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      stopped <= 1'b0;
    else if (ce_i)
    begin
      if (!b.int_n || !b.nmi_n || !b.external_reset_in_n || wdt_expire_i)
        stopped <= 1'b0;
      else if (pd_en && m1_act && !b.halt_n && t_cnt == `CGC_HALT_TSTATE && fall_e)
        stopped <= 1'b1;
    end
  end

  // ----------------------------------------
  // dynamic memory strobes
  // ----------------------------------------
  logic ras, cas;
  assign ras_n_o = !ras;
  assign cas_n_o = !cas;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ras <= 1'b0;
      cas <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!mem_act)
      begin
        ras <= 1'b0;
        cas <= 1'b0;
      end
      else
      begin
        if (dram_acc && rise_e && !mem_start)
          ras <= 1'b1;
        if (ras && fall_e)
          cas <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // wait generators
  // ----------------------------------------
  logic [3:0] wait_cnt, next_wait;
  logic       pfx_pend, ret_chk;
  assign wait_n_o = (wait_cnt == 4'h0);

  always_comb
  begin
    next_wait = 4'h0;
    if (mem_start)
    begin
      if (fetch && cfg_i.op_wait_en)
        next_wait = next_wait + 4'h1;
      if (|mem_hit)
        next_wait = next_wait + {2'b00, cfg_i.mem_ws};
      if (fetch && pfx_pend)
        next_wait = next_wait + 4'h1;
    end
    else if (io_start && ack_act)
      next_wait = {2'b00, cfg_i.ack_ws} + (pif_en ? `CGC_ACK_EXTRA_WS : 4'h0);
    else if (io_start && b.addr[7:0] <= `CGC_IO_WAIT_TOP)
      next_wait = {2'b00, cfg_i.io_ws};
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wait_cnt <= 4'h0;
    else if (ce_i)
    begin
      if (mem_start || io_start)
        wait_cnt <= next_wait;
      else if (ret_chk && wait_cnt == 4'h1 && fall_e)
      begin
        if (b.data == `CGC_RET_BYTE)
          wait_cnt <= ({2'b00, cfg_i.ret_ws} > `CGC_RET_MAX_WS) ?
                      `CGC_RET_MAX_WS : {2'b00, cfg_i.ret_ws};
        else
          wait_cnt <= 4'h0;
      end
      else if (fall_e && wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
    end
  end

  // byte taken while the fetch is live: it leaves the sync with the request
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pfx_pend <= 1'b0;
      ret_chk  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (mem_start && fetch)
      begin
        ret_chk  <= pfx_pend;
        pfx_pend <= 1'b0;
      end
      else if (m1_act && !b.rd_n && !mem_act && !memory_request_q && !m1_q)
        pfx_pend <= pfx_pend;
      else if (fetch && !b.rd_n && b.data == `CGC_PFX_BYTE)
        pfx_pend <= 1'b1;
      if (ret_chk && (wait_cnt == 4'h1) && fall_e)
        ret_chk <= 1'b0;
    end
  end

  // ----------------------------------------
  // reset sequencing
  // ----------------------------------------
  cgc_rst_state_t rs;
  logic [15:0]    por_cnt;
  logic [4:0]     rst_cnt;
  logic           rst_act;
  assign rst_act              = (rs == RS_POR) || (rs == RS_HOLD);
  assign system_reset_out_n_o = !rst_act;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rs      <= RS_POR;
      por_cnt <= 16'h0000;
      rst_cnt <= 5'h00;
    end
    else if (ce_i)
    begin
      case (rs)
        RS_POR:
        begin
          por_cnt <= por_cnt + 16'h0001;
          if (por_cnt == 16'(POR_CLKS - 1))
            rs <= RS_IDLE;
        end
        RS_IDLE:
        begin
          rst_cnt <= 5'h00;
          if (cfg_i.wdt_en && wdt_expire_i)
            rs <= RS_HOLD;
          else if (xrst_fall)
            rs <= RS_ARMED;
        end
        RS_ARMED:
          if (m1_fall)
            rs <= RS_HOLD;
        RS_HOLD:
          if (rise_e)
          begin
            rst_cnt <= rst_cnt + 5'h01;
            if (rst_cnt == `CGC_RST_CLKS - 5'h01)
              rs <= RS_IDLE;
          end
        default:
          rs <= RS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // peripheral strobes and buffered request
  // ----------------------------------------
  logic wr_stb, reg_wr_done;
  logic ack_ready;
  assign ack_ready = ack_act && (wait_cnt == 4'h0);

  // write strobe opens on a rising clock once write is asserted
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wr_stb <= 1'b0;
    else if (ce_i)
    begin
      if (!io_act || b.wr_n)
        wr_stb <= 1'b0;
      else if (rise_e && !m1_act)
        wr_stb <= 1'b1;
    end
  end

  // gating with the live write keeps the strobe inside the data window
  assign periph_write_strobe_n_o = !(rst_act
                                   || (pif_en && wr_stb && io_act && !b.wr_n));
  assign periph_read_strobe_n_o  = !(rst_act
                                   || (pif_en && io_act && !m1_act && !b.rd_n)
                                   || (pif_en && ack_ready));
  assign irq_ack_strobe_n_o      = !(pif_en && ack_act);
  assign buffered_io_request_n_o = !(io_act && (!m1_act || ack_ready));

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reg_write_o <= 1'b0;
      reg_wr_done <= 1'b0;
    end
    else if (ce_i)
    begin
      reg_write_o <= 1'b0;
      if (!io_act)
        reg_wr_done <= 1'b0;
      else if (!reg_wr_done && !m1_act && b.rd_n && !b.wr_n
               && b.addr[7:0] >= `CGC_REG_BASE)
      begin
        reg_write_o <= 1'b1;
        reg_wr_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] hold_rises;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hold_rises <= 5'h00;
    else if (ce_i)
      hold_rises <= (rs == RS_HOLD) ? hold_rises + {4'h0, rise_e} : 5'h00;
  end

  sequence s_row;
    ce_i && dram_acc && mem_act && rise_e && !ras && !mem_start;
  endsequence
  sequence s_col;
    (!ras_n_o && cas_n_o) ##1 !cas_n_o;
  endsequence

  property p_row_then_col;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_row ##1 (ce_i && mem_act) |-> s_col;
  endproperty
  a_row_then_col: assert property (p_row_then_col) else $error("row/column order wrong");

  property p_one_if;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !ras_n_o |-> !ss_sel && cs_sel == 8'h00;
  endproperty
  a_one_if: assert property (p_one_if) else $error("static and dynamic both active");

  property p_wr_window;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !periph_write_strobe_n_o && !rst_act |-> io_act && !b.wr_n && !$past(b.wr_n);
  endproperty
  a_wr_window: assert property (p_wr_window) else $error("write strobe outside window");

  property p_rst_strobes;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !system_reset_out_n_o |-> !periph_read_strobe_n_o && !periph_write_strobe_n_o;
  endproperty
  a_rst_strobes: assert property (p_rst_strobes) else $error("strobes idle during reset");

  property p_rst_len;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(system_reset_out_n_o) && $past(rs) == RS_HOLD |-> hold_rises == 5'h10;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset hold not 16 clocks");

  property p_io_nowait;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && io_start && !m1_act && b.addr[7:0] > `CGC_IO_WAIT_TOP |=> wait_cnt == 4'h0;
  endproperty
  a_io_nowait: assert property (p_io_nowait) else $error("wait on high i/o port");

  property p_pd_low;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    stopped |-> !cpu_clk_o && pd_en;
  endproperty
  a_pd_low: assert property (p_pd_low) else $error("clock not held low");

  property p_pd_wake;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && stopped && (!b.int_n || !b.nmi_n) |=> !stopped ##1 cpu_clk_o;
  endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("clock not restarted");

  property p_pfx_wait;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && mem_start && fetch && pfx_pend |=> wait_cnt != 4'h0 && ret_chk;
  endproperty
  a_pfx_wait: assert property (p_pfx_wait) else $error("prefix wait missing");

endmodule

// ### tb/cgc_cpu_model.sv
// processor-side bus model for the cycle-control glue
// assumes a 25 MHz ref_clk_i; all pins change at its falling edge
`timescale 1ns/1ps
module cgc_cpu_model (
  input  wire logic         ref_clk_i,
  input  wire logic         wait_n_i,
  output cgc_pkg::cgc_bus_t bus_o
);
  import cgc_pkg::*;

  initial
  begin
    bus_o = '{addr: '0, data: '0, default: 1'b1};
  end

  // ----------------------------------------
  // level pins outside any cycle
  // ----------------------------------------
  task automatic side(input logic int_n, input logic rst_n);
    @(negedge ref_clk_i);
    bus_o.int_n               = int_n;
    bus_o.external_reset_in_n = rst_n;
  endtask

  // ----------------------------------------
  // one machine cycle, held long enough for the two-flop sync
  // ----------------------------------------
  task automatic cyc(input logic m1, input logic io, input logic rd,
                     input logic [15:0] a, input logic [7:0] d, input logic hlt);
    int n;
    @(negedge ref_clk_i);
    bus_o.addr                = a;
    bus_o.data                = d;
    bus_o.machine_cycle_one_n = ~m1;
    bus_o.halt_n              = ~hlt;
    bus_o.memory_request_n    = io;
    bus_o.io_request_n        = ~io;
    bus_o.rd_n                = ~rd;
    bus_o.wr_n                = rd;
    repeat (14) @(negedge ref_clk_i);
    n = 0;
    // bounded so a stuck wait line cannot hang the run
    while (wait_n_i !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    // released lines show no stale value
    bus_o = '{addr: ~a, data: ~d, default: 1'b1};
    repeat (6) @(negedge ref_clk_i);
  endtask
endmodule

// ### tb/test_cgc_glue.sv
// self-checking bench for cgc_glue
// assumes cgc_pkg compiled and cgc_params.svh on the include path
`timescale 1ns/1ps
module test_cgc_glue;
  import cgc_pkg::*;

  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        wdt_expire_i = 1'b0;
  cgc_cfg_t    cfg;
  cgc_bus_t    bus;
  logic        cpu_clk, ss_n, ras_n, cas_n, wait_n, rd_n, wr_n, ack_n, bio_n, rst_n, regw, conf;
  logic [7:0]  cs_n;
  logic [17:0] outs, seen, exp_v;
  int          rst_cnt, hi_cnt, failures, samples_checked;
  logic        pfx;
  logic [26:0] row;

  // m1, io, rd, address, data
  localparam logic [26:0] TBL [13] = '{
    {3'b001, 16'h1234, 8'h00}, {3'b001, 16'h8000, 8'h00},
    {3'b101, 16'h8100, 8'hed}, {3'b101, 16'h8101, 8'h00},
    {3'b011, 16'h0014, 8'h00}, {3'b011, 16'h0017, 8'h00},
    {3'b011, 16'h0018, 8'h00}, {3'b011, 16'h003f, 8'h00},
    {3'b010, 16'h0040, 8'h5a}, {3'b010, 16'h008f, 8'ha5},
    {3'b011, 16'h0050, 8'h00}, {3'b010, 16'h00f3, 8'h3c},
    {3'b111, 16'h0000, 8'h00}};

  always #20 ref_clk_i = ~ref_clk_i;

  cgc_cpu_model cpu_u (.ref_clk_i(ref_clk_i), .wait_n_i(wait_n), .bus_o(bus));

  cgc_glue #(.POR_CLKS(8)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .bus_i(bus), .cfg_i(cfg),
    .wdt_expire_i(wdt_expire_i), .cpu_clk_o(cpu_clk), .static_select_n_o(ss_n),
    .decoded_selects_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .wait_n_o(wait_n),
    .periph_read_strobe_n_o(rd_n), .periph_write_strobe_n_o(wr_n),
    .irq_ack_strobe_n_o(ack_n), .buffered_io_request_n_o(bio_n),
    .system_reset_out_n_o(rst_n), .reg_write_o(regw), .cfg_conflict_o(conf));

  // ----------------------------------------
  // monitor: which active-low outputs were ever active
  // ----------------------------------------
  assign outs = {bio_n, ss_n, cs_n, ras_n, cas_n, wait_n, rd_n, wr_n, ack_n, rst_n, ~regw};
  always @(posedge ref_clk_i)
  begin
    seen    <= seen | ~outs;
    rst_cnt <= rst_cnt + int'(rst_n === 1'b0);
    hi_cnt  <= hi_cnt + int'(cpu_clk === 1'b1);
  end

  // ----------------------------------------
  // expected active set, with ss_top 3, io_ws 2, cs0 at 14-17, cs5 at 80-8f
  // ----------------------------------------
  function automatic logic [17:0] exp_lo(input logic m1, input logic io, input logic rd,
                                         input logic [15:0] a, input logic p);
    logic ss;
    logic dr;
    ss = !io && a[15:12] <= 4'h3;
    dr = !io && !ss;
    // acknowledge always waits: two extra states while the strobe interface is on
    return {io, ss, 2'b00, io && a[7:4] == 4'h8, 4'h0, io && a[7:2] == 6'h05, dr, dr,
            io ? (m1 || a[7:0] <= 8'h3f) : m1 && p, io && rd, io && !rd, io && m1, 1'b0,
            io && !rd && a[7:0] >= 8'hf0};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog: whole run is about 440 cycles
  // ----------------------------------------
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end

  initial
  begin
    failures        = 0;
    samples_checked = 0;
    seen            = '0;
    rst_cnt         = 0;
    hi_cnt          = 0;
    pfx             = 1'b0;
    cfg             = '0;
    cfg.master_en    = 1'b1;
    cfg.dram_en      = 1'b1;
    cfg.periph_if_en = 1'b1;
    cfg.wdt_en       = 1'b1;
    cfg.ss_top       = 4'h3;
    cfg.io_ws        = 2'h2;
    cfg.cs[0]        = {2'b11, 6'h05};
    cfg.cs[5]        = {2'b11, 6'h20};
    repeat (5) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    check(rst_n, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    check(rst_n, 1'b1);
    check({seen[4:3], seen[1]}, 3'b111);
    // bus cycles: selects, dram strobes, waits, peripheral strobes
    foreach (TBL[i])
    begin
      row  = TBL[i];
      seen = '0;
      cpu_u.cyc(row[26], row[25], row[24], row[23:8], row[7:0], 1'b0);
      exp_v = exp_lo(row[26], row[25], row[24], row[23:8], pfx);
      check(seen, exp_v);
      if (row[26])
        pfx = row[7:0] == 8'hed;
    end
    cfg.pd_en = 1'b1;
    @(negedge ref_clk_i);
    check(conf, 1'b1);
    cfg.pd_en = 1'b0;
    // external reset waits for the next cycle one
    cpu_u.side(1'b1, 1'b0);
    repeat (8) @(negedge ref_clk_i);
    check(rst_n, 1'b1);
    rst_cnt = 0;
    seen    = '0;
    cpu_u.cyc(1'b1, 1'b0, 1'b1, 16'h8200, 8'h00, 1'b0);
    cpu_u.side(1'b1, 1'b1);
    repeat (30) @(negedge ref_clk_i);
    check(rst_cnt >= 31 && rst_cnt <= 33, 1'b1);
    check(seen[4:3], 2'b11);
    // watchdog expiry
    seen         = '0;
    wdt_expire_i = 1'b1;
    @(negedge ref_clk_i);
    wdt_expire_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check(seen[1], 1'b1);
    repeat (40) @(negedge ref_clk_i);
    // halt power-down, interrupt wakes the clock
    cfg.periph_if_en = 1'b0;
    cfg.pd_en        = 1'b1;
    cpu_u.cyc(1'b1, 1'b0, 1'b1, 16'h0076, 8'h76, 1'b1);
    hi_cnt = 0;
    repeat (10) @(negedge ref_clk_i);
    check(hi_cnt, 0);
    cpu_u.side(1'b0, 1'b1);
    repeat (10) @(negedge ref_clk_i);
    check(hi_cnt > 2, 1'b1);
    cpu_u.side(1'b1, 1'b1);
    complete_run();
  end
endmodule
